// file: hdl/acsc_seq_ctrl.sv
// register file and channel sequencer of the multi-channel converter
// Notes on behaviour
// - in direct mode the ready flag tells the host that fresh results can be read.
// - in automatic mode the ready flag reads zero always.
// - ready is set when a direct-mode pass over all enabled channels has ended.
// - ready clears on a result read or on the start of a new pass.
// - a channel whose enable bit (14,13,11,10,8,7,6,5) is one joins every pass.
// - a channel whose enable bit is zero is skipped and its result left alone.
// - range bit 15-n set selects twice the reference for channel n, else the reference.
// - the enable register resets to 0x0000.
// - the range register resets to 0xff00.
// - mode bit 13 set selects automatic conversion, clear selects direct.
// - writing one to trigger bit 12 starts a pass, and the bit clears when it starts.
module acsc_seq_ctrl
   import acsc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire acsc_req_t hostReq,
   output logic [15:0] readData,
   output logic readValid,
   input wire logic [SAMPLE_W-1:0] sampleData,
   output logic [2:0] channelSel,
   output logic rangeDouble,
   output logic sampleStrobe,
   output logic converting
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] enableBitPos(input logic [2:0] ch);
      case (ch)
         3'h0: enableBitPos = 4'he;
         3'h1: enableBitPos = 4'hd;
         3'h2: enableBitPos = 4'hb;
         3'h3: enableBitPos = 4'ha;
         3'h4: enableBitPos = 4'h8;
         3'h5: enableBitPos = 4'h7;
         3'h6: enableBitPos = 4'h6;
         default: enableBitPos = 4'h5;
      endcase
   endfunction : enableBitPos

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic modeReg, modeNext;
   logic trigReg, trigNext;
   logic [1:0] rateReg, rateNext;
   logic readyReg, readyNext;
   logic [15:0] enableReg, enableNext;
   logic [15:0] rangeReg, rangeNext;
   acsc_state_t stateReg, stateNext;
   logic [2:0] chanReg, chanNext;
   // clocks spent on the current channel
   logic [7:0] divReg, divNext;
   logic rdPendReg, rdMemReg;
   logic [15:0] rdRegReg;
   logic [SAMPLE_W-1:0] memData;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire hitCtrl = hostReq.addr == CONTROL_OFFSET;
   wire hitEnable = hostReq.addr == ENABLE_OFFSET;
   wire hitRange = hostReq.addr == RANGE_OFFSET;
   wire wrCtrl = hostReq.wr && hitCtrl;
   wire wrEnable = hostReq.wr && hitEnable;
   wire wrRange = hostReq.wr && hitRange;
   wire rdResult = hostReq.rd && hostReq.addr >= RESULT_BASE && hostReq.addr <= RESULT_LAST;
   wire [7:0] resultIdx = hostReq.addr - RESULT_BASE;
   wire anyEnabled = |(enableReg & ENABLE_MASK);
   wire chanOn = enableReg[enableBitPos(chanReg)];
   wire lastChan = chanReg == 3'(CHANNELS - 1);
   wire [7:0] periodCycles = SAMPLE_CYCLES_W << rateReg;
   wire tick = divReg == periodCycles - 8'h01;
   wire isIdle = stateReg == SEQ_IDLE;
   wire startPass = isIdle && anyEnabled && (trigReg || modeReg);
   wire takeSample = stateReg == SEQ_RUN && chanOn && tick;
   wire passEnd = stateReg == SEQ_RUN && lastChan && (!chanOn || tick);
   wire autoNow = wrCtrl ? hostReq.wdata[MODE_BIT] : modeReg;
   wire [15:0] ctrlView = {2'h0, modeReg, trigReg, 2'h0, rateReg, readyReg, 7'h00};
   // unmapped addresses read as zero
   wire [15:0] regView = hitCtrl ? ctrlView :
                         hitEnable ? enableReg :
                         hitRange ? rangeReg : 16'h0000;
   acsc_wr_t memWr;

   assign memWr.en = takeSample;
   assign memWr.addr = chanReg;
   assign memWr.data = sampleData;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      modeNext = wrCtrl ? hostReq.wdata[MODE_BIT] : modeReg;
      rateNext = wrCtrl ? hostReq.wdata[RATE_LSB +: 2] : rateReg;
      // a trigger during a pass waits for idle
      trigNext = (wrCtrl && hostReq.wdata[TRIG_BIT]) || (trigReg && !startPass);
      enableNext = wrEnable ? (hostReq.wdata & ENABLE_MASK) : enableReg;
      rangeNext = wrRange ? (hostReq.wdata & RANGE_MASK) : rangeReg;
      // set beats a read clear, auto mode beats both
      readyNext = readyReg;
      if (rdResult || startPass) begin
         readyNext = 1'b0;
      end
      if (passEnd && !modeReg) begin
         readyNext = 1'b1;
      end
      if (autoNow) begin
         readyNext = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      stateNext = stateReg;
      chanNext = chanReg;
      divNext = 8'h00;
      case (stateReg)
         SEQ_IDLE: begin
            if (startPass) begin
               stateNext = SEQ_RUN;
               chanNext = 3'h0;
            end
         end
         SEQ_RUN: begin
            if (chanOn && !tick) begin
               divNext = divReg + 8'h01;
            end else if (lastChan) begin
               stateNext = SEQ_IDLE;
               chanNext = 3'h0;
            end else begin
               chanNext = chanReg + 3'h1;
            end
         end
         default: begin
            stateNext = SEQ_IDLE;
            chanNext = 3'h0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         modeReg <= CONTROL_RESET[MODE_BIT];
         trigReg <= CONTROL_RESET[TRIG_BIT];
         rateReg <= CONTROL_RESET[RATE_LSB +: 2];
         readyReg <= CONTROL_RESET[READY_BIT];
         enableReg <= ENABLE_RESET;
         rangeReg <= RANGE_RESET;
         stateReg <= SEQ_IDLE;
         chanReg <= 3'h0;
         divReg <= 8'h00;
      end else begin
         modeReg <= modeNext;
         trigReg <= trigNext;
         rateReg <= rateNext;
         readyReg <= readyNext;
         enableReg <= enableNext;
         rangeReg <= rangeNext;
         stateReg <= stateNext;
         chanReg <= chanNext;
         divReg <= divNext;
      end
   end

   // ------------------------------------------------------------
   // converter drive
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         channelSel <= 3'h0;
         rangeDouble <= 1'b0;
         sampleStrobe <= 1'b0;
         converting <= 1'b0;
      end else begin
         // channelSel, rangeDouble and converting follow the next-cycle state; sampleStrobe lags takeSample by one cycle
         channelSel <= chanNext;
         rangeDouble <= rangeNext[RANGE_MSB - int'(chanNext)];
         sampleStrobe <= takeSample;
         converting <= stateNext == SEQ_RUN;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // result words come out one edge after the address
   acsc_result_mem resultMem (
      .clk(clk),
      .wrPort(memWr),
      .rdAddr(resultIdx[2:0]),
      .rdData(memData)
   );

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdPendReg <= 1'b0;
         rdMemReg <= 1'b0;
         rdRegReg <= 16'h0000;
         readData <= 16'h0000;
         readValid <= 1'b0;
      end else begin
         rdPendReg <= hostReq.rd;
         rdMemReg <= rdResult;
         rdRegReg <= regView;
         readValid <= rdPendReg;
         if (rdPendReg) begin
            readData <= rdMemReg ? {6'h00, memData} : rdRegReg;
         end
      end
   end
endmodule : acsc_seq_ctrl

// file: hdl/acsc_pkg.sv
// constants and carrier types of the conversion sequence controller
package acsc_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CONTROL_OFFSET = 8'h36;
   localparam logic [7:0] ENABLE_OFFSET = 8'h37;
   localparam logic [7:0] RANGE_OFFSET = 8'h38;
   localparam logic [7:0] RESULT_BASE = 8'h23;
   localparam logic [7:0] RESULT_LAST = 8'h2a;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int MODE_BIT = 13;
   localparam int TRIG_BIT = 12;
   localparam int RATE_LSB = 8;
   localparam int READY_BIT = 7;
   localparam int RANGE_MSB = 15;

   // ------------------------------------------------------------
   // reset values and write masks
   // ------------------------------------------------------------
   localparam logic [15:0] CONTROL_RESET = 16'h2000;
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [15:0] RANGE_RESET = 16'hff00;
   localparam logic [15:0] ENABLE_MASK = 16'h6de0;
   localparam logic [15:0] RANGE_MASK = 16'hff00;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SAMPLE_PERIOD_NS = 2000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] SAMPLE_CYCLES_W = 8'(SAMPLE_CYCLES);

   // ------------------------------------------------------------
   // widths and carriers
   // ------------------------------------------------------------
   localparam int CHANNELS = 8;
   localparam int SAMPLE_W = 10;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } acsc_req_t;

   typedef struct packed {
      logic en;
      logic [2:0] addr;
      logic [SAMPLE_W-1:0] data;
   } acsc_wr_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_RUN = 2'b10
   } acsc_state_t;
endpackage : acsc_pkg

// file: hdl/acsc_result_mem.sv
// eight-word result store with registered read data
module acsc_result_mem
   import acsc_pkg::*;
(
   input wire logic clk,
   input wire acsc_wr_t wrPort,
   input wire logic [2:0] rdAddr,
   output logic [SAMPLE_W-1:0] rdData
);
   logic [SAMPLE_W-1:0] words [CHANNELS];

   always_ff @(posedge clk) begin
      if (wrPort.en) begin
         words[wrPort.addr] <= wrPort.data;
      end
      rdData <= words[rdAddr];
   end
endmodule : acsc_result_mem

// file: test/acsc_seq_ctrl_chk.sv
// port-level assertions of the conversion sequence controller
module acsc_seq_ctrl_chk
   import acsc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire acsc_req_t hostReq,
   input wire logic [15:0] readData,
   input wire logic readValid,
   input wire logic [SAMPLE_W-1:0] sampleData,
   input wire logic [2:0] channelSel,
   input wire logic rangeDouble,
   input wire logic sampleStrobe,
   input wire logic converting
);
   logic [15:0] enReg;
   logic [15:0] rngReg;
   logic modeReg;
   wire logic [7:0] chOn = {enReg[5], enReg[6], enReg[7], enReg[8],
                            enReg[10], enReg[11], enReg[13], enReg[14]};
   wire logic wrCtl = hostReq.wr && hostReq.addr == CONTROL_OFFSET;
   // shadow of the host-written registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enReg <= ENABLE_RESET;
         rngReg <= RANGE_RESET;
         modeReg <= 1'b1;
      end else begin
         if (hostReq.wr && hostReq.addr == ENABLE_OFFSET) enReg <= hostReq.wdata & ENABLE_MASK;
         if (hostReq.wr && hostReq.addr == RANGE_OFFSET) rngReg <= hostReq.wdata & RANGE_MASK;
         if (wrCtl) modeReg <= hostReq.wdata[MODE_BIT];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_read_answer; hostReq.rd |-> ##2 readValid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer late");
   property p_ready_auto;
      hostReq.rd && !hostReq.wr && hostReq.addr == CONTROL_OFFSET && modeReg
         |-> ##2 !readData[READY_BIT];
   endproperty
   a_ready_auto: assert property (p_ready_auto) else $error("ready set in auto mode");
   property p_trig_start;
      wrCtl && hostReq.wdata[TRIG_BIT] && enReg != 16'h0000 && !converting |-> ##[1:3] converting;
   endproperty
   a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
   property p_skip; sampleStrobe |-> chOn[$past(channelSel)]; endproperty
   a_skip: assert property (p_skip) else $error("disabled channel stored");
   property p_period; sampleStrobe |-> $past(channelSel, 20) == $past(channelSel); endproperty
   a_period: assert property (p_period) else $error("channel period too short");
   property p_range;
      $past(rstn, 2) && $stable(channelSel) && $past(channelSel, 2) == channelSel
         && !$past(hostReq.wr) && !$past(hostReq.wr, 2) |-> rangeDouble == rngReg[RANGE_MSB - channelSel];
   endproperty
   a_range: assert property (p_range) else $error("range select wrong");
   property p_en_back;
      hostReq.rd && !hostReq.wr && hostReq.addr == ENABLE_OFFSET ##1 !hostReq.wr |-> ##1 readData == enReg;
   endproperty
   a_en_back: assert property (p_en_back) else $error("enable readback wrong");
   property p_rng_back;
      hostReq.rd && !hostReq.wr && hostReq.addr == RANGE_OFFSET ##1 !hostReq.wr |-> ##1 readData == rngReg;
   endproperty
   a_rng_back: assert property (p_rng_back) else $error("range readback wrong");
endmodule : acsc_seq_ctrl_chk
bind acsc_seq_ctrl acsc_seq_ctrl_chk i_chk (.clk(clk), .rstn(rstn), .hostReq(hostReq),
   .readData(readData), .readValid(readValid), .sampleData(sampleData), .channelSel(channelSel),
   .rangeDouble(rangeDouble), .sampleStrobe(sampleStrobe), .converting(converting));

// file: test/tb_top.sv
// self-checking bench of the conversion sequence controller
module tb_top import acsc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   acsc_req_t req = '0;
   logic [SAMPLE_W-1:0] sd = '0;
   logic [15:0] rdData;
   logic rdValid, rngDbl, strobe, conv;
   logic [2:0] chSel;
   int nMismatch = 0;
   int cmpCount = 0;
   int n;
   always #50 clk = ~clk;
   acsc_seq_ctrl i_dut (.clk(clk), .rstn(rstn), .hostReq(req), .readData(rdData),
      .readValid(rdValid), .sampleData(sd), .channelSel(chSel), .rangeDouble(rngDbl),
      .sampleStrobe(strobe), .converting(conv));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nMismatch++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      req = '{1'b1, 1'b0, a, d};
      @(posedge clk) #10;
      req = '0;
      @(posedge clk) #10;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      req = '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk) #10;
      req = '0;
      for (int i = 0; i < 4 && rdValid !== 1'b1; i++) @(posedge clk) #10;
      if (rdValid !== 1'b1) nMismatch++;
      chk(rdData, e);
   endtask : rd
   task automatic waitIdle();
      n = 0;
      while (conv === 1'b1 && n < 4000) begin
         @(posedge clk) #10;
         n++;
      end
      if (conv !== 1'b0) nMismatch++;
   endtask : waitIdle
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmpCount, nMismatch);
      if (nMismatch == 0 && cmpCount > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // ------------------------------------------------------------
   // watchdog and test sequence
   // ------------------------------------------------------------
   initial begin
      #1000000;
      nMismatch++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge clk);
      #10 rstn = 1'b1;
      rd(ENABLE_OFFSET, ENABLE_RESET);
      rd(RANGE_OFFSET, RANGE_RESET);
      rd(CONTROL_OFFSET, CONTROL_RESET);
      $display("test reset values done");
      wr(CONTROL_OFFSET, 16'h0000);
      wr(ENABLE_OFFSET, 16'hedff);
      rd(ENABLE_OFFSET, ENABLE_MASK);
      wr(RANGE_OFFSET, 16'h5aff);
      chk({15'h0000, rngDbl}, 16'h0000);
      rd(RANGE_OFFSET, 16'h5a00);
      $display("test write masks done");
      wr(ENABLE_OFFSET, 16'h4020);
      sd = 10'h155;
      wr(CONTROL_OFFSET, 16'h1000);
      @(posedge clk) #10;
      waitIdle();
      rd(CONTROL_OFFSET, 16'h0080);
      sd = 10'h0aa;
      wr(ENABLE_OFFSET, 16'h4000);
      wr(CONTROL_OFFSET, 16'h1000);
      rd(CONTROL_OFFSET, 16'h0000);
      waitIdle();
      rd(RESULT_BASE, 16'h00aa);
      rd(RESULT_LAST, 16'h0155);
      rd(CONTROL_OFFSET, 16'h0000);
      $display("test direct pass done");
      for (int r = 0; r < 4; r++) begin
         wr(CONTROL_OFFSET, 16'h1000 | 16'(r << RATE_LSB));
         @(posedge clk) #10;
         waitIdle();
         chk(16'(n >= (20 << r) && n < (20 << r) + 12), 16'h0001);
      end
      $display("test rates done");
      wr(CONTROL_OFFSET, CONTROL_RESET);
      @(posedge clk) #10;
      chk({15'h0000, conv}, 16'h0001);
      rd(CONTROL_OFFSET, CONTROL_RESET);
      waitIdle();
      rd(CONTROL_OFFSET, CONTROL_RESET);
      chk({15'h0000, conv}, 16'h0001);
      $display("test auto mode done");
      tally_and_finish();
   end
endmodule : tb_top
